// [pa_ramp_pkg.sv]
// Package with constants and carrier types for the power ramp shaper.
package pa_ramp_pkg;

	localparam int TABLE_DEPTH = 8;
	localparam int INDEX_W = 3;
	localparam int SETTING_W = 8;
	localparam logic [7:0] TABLE_RESET = 8'hC6;
	localparam logic [2:0] INDEX_ZERO = 3'h0;
	localparam logic [2:0] OOK_ONE_INDEX = 3'h1;
	localparam int SHAPE_RATE = 8;
	localparam logic [2:0] TICK_LAST = 3'h7;

	typedef enum logic [1:0] {
		MOD_FSK,
		MOD_OOK,
		MOD_ASK
	} mod_fmt_t;

	typedef enum {
		ST_IDLE,
		ST_RAMP_UP,
		ST_BODY,
		ST_RAMP_DOWN
	} ramp_state_t;

	typedef struct packed {
		logic wr_en;
		logic [2:0] wr_index;
		logic [7:0] wr_data;
	} table_write_t;

	typedef struct packed {
		logic [2:0] power_index_limit;
		mod_fmt_t mod_fmt;
	} front_end_config_t;

endpackage

// [power_index_limit_ramp_shaper.sv]
// Power level table with ramp, on-off keying and amplitude shaping index.
`timescale 1ns/1ns
module power_index_limit_ramp_shaper
	import pa_ramp_pkg::*;
#(
	parameter int DEPTH = TABLE_DEPTH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire table_write_t table_write,
	input wire front_end_config_t front_end_config,
	input wire logic tx_active,
	input wire logic shape_tick,
	input wire logic tx_symbol,
	output logic [7:0] pa_setting,
	output logic [2:0] table_index,
	output logic ramp_busy
);

	logic [7:0] power_level_table [DEPTH];
	logic [2:0] index_q;
	logic [2:0] index_d;
	logic [7:0] setting_q;
	ramp_state_t state_q;
	ramp_state_t state_d;
	logic [2:0] limit;
	logic at_top;
	logic at_zero;
	logic fsk_mode;
	logic [2:0] ask_index;
	logic [2:0] ook_index;

	assign limit = front_end_config.power_index_limit;
	assign fsk_mode = (front_end_config.mod_fmt == MOD_FSK);
	assign at_top = (index_q >= limit);
	assign at_zero = (index_q == INDEX_ZERO);

	// Writes land in any entry; the serial front end is what restricts
	// single accesses to entry zero, so this store stays simple.
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					power_level_table[g] <= TABLE_RESET;
				end else if (table_write.wr_en &&
						table_write.wr_index == 3'(g)) begin
					power_level_table[g] <= table_write.wr_data;
				end
			end
		end
	endgenerate

	// Next packet phase; only frequency keying ramps, the keyed formats
	// shape through the table themselves.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (tx_active && fsk_mode) begin
					state_d = ST_RAMP_UP;
				end else if (tx_active) begin
					state_d = ST_BODY;
				end
			end
			ST_RAMP_UP: begin
				if (!tx_active) begin
					state_d = ST_RAMP_DOWN;
				end else if (at_top) begin
					state_d = ST_BODY;
				end
			end
			ST_BODY: begin
				if (!tx_active && fsk_mode) begin
					state_d = ST_RAMP_DOWN;
				end else if (!tx_active) begin
					state_d = ST_IDLE;
				end
			end
			ST_RAMP_DOWN: begin
				if (at_zero) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// Amplitude shaping step; a one above a lowered limit snaps back to
	// the limit instead of counting, so the index never passes the top.
	always_comb begin
		ask_index = index_q;
		if (shape_tick) begin
			if (tx_symbol && !at_top) begin
				ask_index = index_q + 3'h1;
			end else if (tx_symbol) begin
				ask_index = limit;
			end else if (!at_zero) begin
				ask_index = index_q - 3'h1;
			end
		end
	end

	// Entry one holds the keyed-on level, entry zero the keyed-off level.
	always_comb begin
		ook_index = INDEX_ZERO;
		if (tx_symbol) begin
			ook_index = OOK_ONE_INDEX;
		end
	end

	// Table index for the next cycle; ramps only move on a shaping tick,
	// which keeps ramp speed tied to the symbol rate.
	always_comb begin
		index_d = index_q;
		unique case (state_q)
			ST_IDLE: begin
				index_d = INDEX_ZERO;
			end
			ST_RAMP_UP: begin
				if (!tx_active) begin
					index_d = index_q;
				end else if (at_top) begin
					index_d = limit;
				end else if (shape_tick) begin
					index_d = index_q + 3'h1;
				end
			end
			ST_BODY: begin
				if (!tx_active && !fsk_mode) begin
					// Keyed formats end with no ramp, so drop to entry zero
					// now rather than leave a keyed level on while idle.
					index_d = INDEX_ZERO;
				end else if (!tx_active) begin
					index_d = index_q;
				end else begin
					unique case (front_end_config.mod_fmt)
						MOD_OOK: begin
							index_d = ook_index;
						end
						MOD_ASK: begin
							index_d = ask_index;
						end
						default: begin
							index_d = limit;
						end
					endcase
				end
			end
			ST_RAMP_DOWN: begin
				if (!at_zero && shape_tick) begin
					index_d = index_q - 3'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			index_q <= INDEX_ZERO;
		end else begin
			index_q <= index_d;
		end
	end

	// The setting is registered one cycle behind the index so the analog
	// side always sees a stable byte rather than a decoder glitch.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			setting_q <= TABLE_RESET;
		end else begin
			setting_q <= power_level_table[index_q];
		end
	end

	assign pa_setting = setting_q;
	assign table_index = index_q;

	// Ramp status decodes straight from the phase register, so it settles
	// right after the edge and carries no counter glitches.
	always_comb begin
		ramp_busy = 1'h0;
		unique case (state_q)
			ST_IDLE: begin
				ramp_busy = 1'h0;
			end
			ST_RAMP_UP: begin
				ramp_busy = 1'h1;
			end
			ST_BODY: begin
				ramp_busy = 1'h0;
			end
			ST_RAMP_DOWN: begin
				ramp_busy = 1'h1;
			end
		endcase
	end

endmodule

// [pa_ramp_monitor.sv]
// Checker bound to the power ramp shaper.
`timescale 1ns/1ns
module pa_ramp_monitor
	import pa_ramp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire table_write_t table_write,
	input wire front_end_config_t front_end_config,
	input wire logic tx_active,
	input wire logic shape_tick,
	input wire logic tx_symbol,
	input wire logic [7:0] pa_setting,
	input wire logic [2:0] table_index,
	input wire logic ramp_busy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic p;
	wire [2:0] l = front_end_config.power_index_limit;
	wire [2:0] i = table_index;
	wire [1:0] f = front_end_config.mod_fmt;
	wire t = tx_active;
	wire k = t && p;
	wire ak = k && f == MOD_ASK;
	wire b = ramp_busy;
	always_ff @(posedge clk_sys) p <= t;
	AST_SAT: assert property (ak |-> i <= l)
		else $error("over limit");
	AST_UP: assert property (ak && shape_tick && tx_symbol && i < l ##1 t
		|-> i == $past(i) + 3'h1) else $error("no up step");
	AST_DN: assert property (ak && shape_tick && !tx_symbol && i > 0 ##1 t
		|-> i == $past(i) - 3'h1) else $error("no down step");
	AST_FSK: assert property (k && !b && f == MOD_FSK |-> i == l)
		else $error("body off limit");
	AST_OOK: assert property (k && f == MOD_OOK ##1 t
		|-> i == {2'h0, $past(tx_symbol)}) else $error("ook level");
	AST_IDLE: assert property (!t && !p && !ramp_busy |-> i == 3'h0)
		else $error("idle not zero");
	AST_LIM0: assert property (l == 3'h0 && f != MOD_OOK |-> i == 3'h0)
		else $error("ramp at zero limit");
	AST_HOLD: assert property (ramp_busy && t && !shape_tick ##1 ramp_busy
		|-> $stable(i)) else $error("step off tick");
endmodule
bind power_index_limit_ramp_shaper pa_ramp_monitor i_pa_ramp_monitor(.*);

// [pa_mod_model.sv]
// Modulator model pacing shaping ticks and symbols.
`timescale 1ns/1ns
module pa_mod_model (
	input wire logic clk_sys,
	input wire logic sym_in,
	output logic shape_tick = 1'h0,
	output logic tx_symbol = 1'h0
);
	logic [4:0] cnt_q = 5'h00;
	// A symbol lasts eight ticks, so shaping runs at eight times its rate.
	always_ff @(posedge clk_sys) begin
		cnt_q <= cnt_q + 5'h01;
		shape_tick <= cnt_q[1:0] == 2'h3;
		if (cnt_q == 5'h1f) tx_symbol <= sym_in;
	end
endmodule

// [power_index_limit_ramp_shaper_test.sv]
// Bench comparing the power ramp shaper with a reference model.
`timescale 1ns/1ns
module power_index_limit_ramp_shaper_test;
	import pa_ramp_pkg::*;
	logic clk_sys = 1'h0, arst_n = 1'h0, tx_active = 1'h0, sym_in = 1'h0;
	logic shape_tick, tx_symbol, ramp_busy;
	logic [7:0] pa_setting, ep = TABLE_RESET, tb [8];
	logic [2:0] table_index, m = 3'h0, l;
	logic [2:0] lims [3] = '{3'h0, 3'h2, 3'h7};
	logic [31:0] rnd = 32'h0000_fe41;
	table_write_t table_write = '0;
	front_end_config_t front_end_config = '0;
	mod_fmt_t f;
	int mismatches = 0, checks_done = 0, st = 0;
	power_index_limit_ramp_shaper i_power_index_limit_ramp_shaper(.*);
	pa_mod_model i_pa_mod_model(.*);
	initial forever #2 clk_sys = ~clk_sys;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic run(input mod_fmt_t fm, input logic [2:0] lm);
		front_end_config <= '{lm, fm};
		for (int k = 0; k < 8; k++) begin
			rnd = rnd ^ (rnd << 13);
			rnd = rnd ^ (rnd >> 17);
			rnd = rnd ^ (rnd << 5);
			if (rnd[7:4] == 4'h6) rnd[7] = 1'h1;
			table_write <= '{1'h1, 3'(k), rnd[7:0]};
			@(posedge clk_sys);
		end
		table_write <= '0;
		tx_active <= 1'h1;
		repeat (150) begin
			@(posedge clk_sys);
			sym_in <= rnd[checks_done % 32];
		end
		tx_active <= 1'h0;
		repeat (40) @(posedge clk_sys);
		$display("test done fmt %0d limit %0d", fm, lm);
	endtask
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st = 0;
			m = 3'h0;
			foreach (tb[n]) tb[n] = TABLE_RESET;
		end else begin
			ep = tb[m];
			if (table_write.wr_en) tb[table_write.wr_index] = table_write.wr_data;
			l = front_end_config.power_index_limit;
			f = front_end_config.mod_fmt;
			case (st)
			0: st = tx_active ? (f == MOD_FSK ? 1 : 2) : 0;
			1: if (m >= l) begin
				st = 2;
				m = l;
			end else if (shape_tick) m++;
			2: if (!tx_active) begin
				st = f == MOD_FSK ? 3 : 0;
				m = st ? m : 3'h0;
			end else if (f == MOD_FSK) m = l;
			else if (f == MOD_OOK) m = {2'h0, tx_symbol};
			else if (shape_tick) m = tx_symbol ? (m < l ? m + 3'h1 : l)
				: (m ? m - 3'h1 : 3'h0);
			3: if (m == 3'h0) st = 0;
			else if (shape_tick) m--;
			endcase
		end
	end
	always @(negedge clk_sys) if (arst_n) begin
		cmp(pa_setting, ep);
		cmp({4'h0, ramp_busy, table_index}, {4'h0, st[0], m});
	end
	initial begin
		#60000;
		mismatches++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'h1;
		for (int q = 0; q < 9; q++) begin
			@(posedge clk_sys);
			run(mod_fmt_t'(q / 3), lims[q % 3]);
		end
		complete_run;
	end
endmodule
